// *** cpai_pkg.sv ***
// cpai_pkg: shared constants, types and priority helpers for the cascaded controller pair.
// assumes a byte-wide processor I/O port space decoded on 16-bit addresses.
package cpai_pkg;
    localparam logic [15:0] MST_BASE_ADDR = 16'h0020;
    localparam logic [15:0] MST_DATA_ADDR = 16'h0021;
    localparam logic [15:0] SLV_BASE_ADDR = 16'h00A0;
    localparam logic [15:0] SLV_DATA_ADDR = 16'h00A1;
    localparam int          INIT_BIT      = 4;
    localparam int          OP_WORD_READ_POLL_SEL_BIT  = 3;
    localparam int          OP_WORD_READ_POLL_ESMM_BIT = 6;
    localparam int          OP_WORD_READ_POLL_SMM_BIT  = 5;
    localparam int          OP_WORD_READ_POLL_POLL_BIT = 2;
    localparam int          OP_WORD_READ_POLL_RR_BIT   = 1;
    localparam int          OP_WORD_READ_POLL_RIS_BIT  = 0;
    localparam int          MODE_AUTO_END_OF_SERVICE_BIT = 1;
    localparam int          CASCADE_INPUT = 2;
    localparam logic [2:0]  LOWEST_LEVEL  = 3'h7;
    localparam logic [2:0]  SLAVE_ADDR_RST = 3'h7;
    localparam logic [2:0]  SLAVE_ID_CODE = 3'h2;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    localparam logic [7:0]  BYTE_ONES     = 8'hFF;
    // rotate / select / end-of-service command field, bits 7:5
    localparam logic [2:0]  CMD_ROT_AUTO_END_OF_SERVICE_CLR = 3'h0;
    localparam logic [2:0]  CMD_NS_EOS       = 3'h1;
    localparam logic [2:0]  CMD_SP_EOS       = 3'h3;
    localparam logic [2:0]  CMD_ROT_AUTO_END_OF_SERVICE_SET = 3'h4;
    localparam logic [2:0]  CMD_ROT_NS_EOS   = 3'h5;
    localparam logic [2:0]  CMD_SET_PRIO     = 3'h6;
    localparam logic [2:0]  CMD_ROT_SP_EOS   = 3'h7;

    typedef enum logic [2:0] {ST_IDLE, ST_ACK1, ST_TRAIL1, ST_ACK2, ST_TRAIL2} cpai_ack_state_t;
    typedef enum logic [1:0] {STEP_RUN, STEP_VEC, STEP_CAS, STEP_MODE} cpai_init_step_t;

    // highest-priority set bit given the bottom-priority level; {found, level}
    function automatic logic [3:0] cpai_pick(input logic [7:0] bits, input logic [2:0] bottom);
        logic [3:0] res;
        logic [2:0] lvl;
        res = {1'b0, LOWEST_LEVEL};
        for (int i = 7; i >= 0; i--) begin
            lvl = bottom + 3'(i + 1);
            if (bits[lvl]) res = {1'b1, lvl};
        end
        return res;
    endfunction

    // rank 0 is the highest priority
    function automatic logic [2:0] cpai_rank(input logic [2:0] lvl, input logic [2:0] bottom);
        return 3'(lvl - bottom - 3'h1);
    endfunction
endpackage

// *** cpai_core.sv ***
// cpai_core: one controller core: request latch, mask, in-service, priority, command words.
// assumes requests are already synchronised and strobes are one-cycle pulses.
`timescale 1ns/100ps
module cpai_core import cpai_pkg::*; (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_req,
    input  wire logic [7:0] i_trig_level,
    input  wire logic       i_wr_base,
    input  wire logic       i_wr_data,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_rd_base,
    input  wire logic       i_freeze,
    input  wire logic       i_commit,
    input  wire logic       i_release,
    output logic            o_int,
    output logic [7:0]      o_vector,
    output logic [7:0]      o_status,
    output logic [7:0]      o_mask,
    output logic [7:0]      o_cascade,
    output logic [7:0]      o_irr,
    output logic [7:0]      o_isr,
    output logic [2:0]      o_frz_lvl,
    output logic            o_frz_hit,
    output logic            o_auto_end_of_service,
    output logic            o_init_busy
);
    logic [7:0] irr_ff, isr_ff, imr_ff, blk_ff, prev_ff, casc_ff, mode_ff;
    logic [7:0] nxt_irr, nxt_isr, nxt_imr, nxt_blk, nxt_casc, nxt_mode, setm, act_isr;
    logic [4:0] vbase_ff, nxt_vbase;
    logic [2:0] bottom_ff, nxt_bottom, frz_lvl_ff, nxt_frz_lvl, r_lvl, commit_lvl;
    logic [3:0] pend_pick, isr_pick;
    logic       smm_ff, rd_isr_ff, poll_ff, rot_auto_end_of_service_ff, frz_hit_ff, int_req, r_hit, commit_now;
    logic       nxt_smm, nxt_rd_isr, nxt_poll, nxt_rot_auto_end_of_service, nxt_frz_hit;
    cpai_init_step_t step_ff, nxt_step;

    always_comb begin
        act_isr   = smm_ff ? (isr_ff & ~imr_ff) : isr_ff;
        pend_pick = cpai_pick(irr_ff & ~imr_ff, bottom_ff);
        isr_pick  = cpai_pick(act_isr, bottom_ff);
        // masked levels never reach the interrupt output; nesting blocks same/lower
        int_req   = pend_pick[3] && (!isr_pick[3] ||
                    cpai_rank(pend_pick[2:0], bottom_ff) < cpai_rank(isr_pick[2:0], bottom_ff));
        r_hit = i_freeze ? int_req : frz_hit_ff;
        r_lvl = i_freeze ? (int_req ? pend_pick[2:0] : LOWEST_LEVEL) : frz_lvl_ff;
        commit_now = (i_commit && r_hit) || (i_rd_base && poll_ff && int_req);
        commit_lvl = (i_rd_base && poll_ff) ? pend_pick[2:0] : r_lvl;
        nxt_blk = blk_ff & i_req;
        setm = (i_trig_level & i_req | ~i_trig_level & i_req & ~prev_ff) & ~blk_ff;
        nxt_irr = (irr_ff & i_req) | setm;
        nxt_isr = isr_ff;       nxt_imr = imr_ff;        nxt_casc = casc_ff;
        nxt_mode = mode_ff;     nxt_vbase = vbase_ff;    nxt_bottom = bottom_ff;
        nxt_smm = smm_ff;       nxt_rd_isr = rd_isr_ff;  nxt_poll = poll_ff;
        nxt_rot_auto_end_of_service = rot_auto_end_of_service_ff;  nxt_step = step_ff;
        nxt_frz_hit = r_hit;    nxt_frz_lvl = r_lvl;
        if (commit_now) nxt_irr[commit_lvl] = setm[commit_lvl];
        if (i_rd_base && poll_ff) nxt_poll = 1'b0;
        if (i_release && mode_ff[MODE_AUTO_END_OF_SERVICE_BIT] && frz_hit_ff) begin
            nxt_isr[frz_lvl_ff] = 1'b0;
            if (rot_auto_end_of_service_ff) nxt_bottom = frz_lvl_ff;
        end
        if (i_wr_base && i_wdata[INIT_BIT]) begin
            nxt_imr = BYTE_ZERO;  nxt_blk = BYTE_ONES;  nxt_irr = BYTE_ZERO;
            nxt_bottom = LOWEST_LEVEL;  nxt_casc = {5'h00, SLAVE_ADDR_RST};
            nxt_smm = 1'b0;  nxt_rd_isr = 1'b0;  nxt_poll = 1'b0;
            nxt_mode = BYTE_ZERO;  nxt_step = STEP_VEC;
        end else if (i_wr_base && i_wdata[OP_WORD_READ_POLL_SEL_BIT]) begin
            if (i_wdata[OP_WORD_READ_POLL_ESMM_BIT]) nxt_smm = i_wdata[OP_WORD_READ_POLL_SMM_BIT];
            if (i_wdata[OP_WORD_READ_POLL_RR_BIT]) nxt_rd_isr = i_wdata[OP_WORD_READ_POLL_RIS_BIT];
            nxt_poll = i_wdata[OP_WORD_READ_POLL_POLL_BIT];
        end else if (i_wr_base) begin
            case (i_wdata[7:5])
                CMD_NS_EOS:       if (isr_pick[3]) nxt_isr[isr_pick[2:0]] = 1'b0;
                CMD_ROT_NS_EOS: begin
                    if (isr_pick[3]) nxt_isr[isr_pick[2:0]] = 1'b0;
                    if (isr_pick[3]) nxt_bottom = isr_pick[2:0];
                end
                CMD_SP_EOS:       nxt_isr[i_wdata[2:0]] = 1'b0;
                CMD_ROT_SP_EOS: begin
                    nxt_isr[i_wdata[2:0]] = 1'b0;
                    nxt_bottom = i_wdata[2:0];
                end
                CMD_SET_PRIO:     nxt_bottom = i_wdata[2:0];
                CMD_ROT_AUTO_END_OF_SERVICE_SET: nxt_rot_auto_end_of_service = 1'b1;
                CMD_ROT_AUTO_END_OF_SERVICE_CLR: nxt_rot_auto_end_of_service = 1'b0;
                default: ;
            endcase
        end else if (i_wr_data) begin
            case (step_ff)
                STEP_VEC: begin
                    nxt_vbase = i_wdata[7:3];
                    nxt_step = STEP_CAS;
                end
                STEP_CAS: begin
                    nxt_casc = i_wdata;
                    nxt_step = STEP_MODE;
                end
                STEP_MODE: begin
                    nxt_mode = i_wdata;
                    nxt_step = STEP_RUN;
                end
                default: nxt_imr = i_wdata;
            endcase
        end
        // set after command decode so a same-cycle end of service loses
        if (commit_now) nxt_isr[commit_lvl] = 1'b1;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irr_ff <= BYTE_ZERO;  isr_ff <= BYTE_ZERO;  imr_ff <= BYTE_ONES;
            blk_ff <= BYTE_ZERO;  prev_ff <= BYTE_ZERO;  casc_ff <= {5'h00, SLAVE_ADDR_RST};
            mode_ff <= BYTE_ZERO;  vbase_ff <= 5'h00;  bottom_ff <= LOWEST_LEVEL;
            smm_ff <= 1'b0;  rd_isr_ff <= 1'b0;  poll_ff <= 1'b0;  rot_auto_end_of_service_ff <= 1'b0;
            frz_lvl_ff <= LOWEST_LEVEL;  frz_hit_ff <= 1'b0;  step_ff <= STEP_RUN;
        end else begin
            irr_ff <= nxt_irr;  isr_ff <= nxt_isr;  imr_ff <= nxt_imr;
            blk_ff <= nxt_blk;  prev_ff <= i_req;  casc_ff <= nxt_casc;
            mode_ff <= nxt_mode;  vbase_ff <= nxt_vbase;  bottom_ff <= nxt_bottom;
            smm_ff <= nxt_smm;  rd_isr_ff <= nxt_rd_isr;  poll_ff <= nxt_poll;
            rot_auto_end_of_service_ff <= nxt_rot_auto_end_of_service;  frz_lvl_ff <= nxt_frz_lvl;
            frz_hit_ff <= nxt_frz_hit;  step_ff <= nxt_step;
        end
    end

    assign o_int       = int_req;
    assign o_vector    = {vbase_ff, frz_lvl_ff};
    assign o_status    = poll_ff ? {int_req, 4'h0, pend_pick[2:0]} : (rd_isr_ff ? isr_ff : irr_ff);
    assign o_mask      = imr_ff;
    assign o_cascade   = casc_ff;
    assign o_irr       = irr_ff;
    assign o_isr       = isr_ff;
    assign o_frz_lvl   = frz_lvl_ff;
    assign o_frz_hit   = frz_hit_ff;
    assign o_auto_end_of_service      = mode_ff[MODE_AUTO_END_OF_SERVICE_BIT];
    assign o_init_busy = (step_ff != STEP_RUN);
endmodule

// *** cpai_top.sv ***
// cpai_top: master/slave controller pair with I/O port decode and acknowledge sequencing.
// assumes I/O strobes and the acknowledge command are one-cycle pulses on I_CLK_SYS;
// request pins are asynchronous and are synchronised here.
// What this block does
// - request latch sets on rising edge or high level, whatever the mask
// - masked level never drives the processor interrupt output
// - interrupt output goes low while an unmasked pending request outranks the highest active in-service level
// - acknowledged level gets in-service bit set and request bit cleared
// - each bus acknowledge command becomes two internal acknowledge pulses; the second reaches only a matching slave
// - first pulse freezes priority, sets top in-service bit, clears its request bit
// - first pulse trailing edge sends slave code on private 3-bit bus
// - vector is base bits 7:3 plus level code in bits 2:0
// - vanished request returns the master level 7 vector
// - automatic mode clears in-service after second pulse, else wait for command
// - master answers at 20h, slave at A0h
// - base write with bit 4 set starts init; three data-port writes follow
// - init clears mask; inputs need a fresh rising edge afterwards
// - init sets level 7 lowest, slave address 7, no special masking, request read
// - slave answers only when broadcast code matches its cascade word
// - mask word written at data port sets per-level mask
// - rotate/end-of-service word rotates priority and ends service
// - read/poll word picks status source, special masking and polling
// - slave returns the vector when master drives code 010
// - fixed priority runs from level 0 highest to level 7 lowest
// - non-specific end of service clears the highest active in-service bit; special masking skips masked levels
`timescale 1ns/100ps
module cpai_top import cpai_pkg::*; (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RST,
    input  wire logic [15:0] I_IRQ,
    input  wire logic [15:0] I_TRIG_LEVEL,
    input  wire logic [15:0] I_IO_ADDR,
    input  wire logic        I_IO_WR,
    input  wire logic        I_IO_RD,
    input  wire logic [7:0]  I_IO_WDATA,
    input  wire logic        I_INTERNAL_ACK_PULSE_CMD,
    output logic [7:0]       O_IO_RDATA,
    output logic             O_IO_RVALID,
    output logic             O_CPU_INT_N,
    output logic [7:0]       O_VECTOR,
    output logic             O_VECTOR_VALID,
    output logic             O_ACK_BUSY
);
    logic [15:0] irq_s1_ff, irq_s2_ff;
    logic [7:0]  m_req, m_trig;
    logic [7:0]  m_vector, m_status, m_mask, m_cascade, m_irr, m_isr;
    logic [7:0]  s_vector, s_status, s_mask, s_cascade;
    logic [2:0]  m_frz_lvl;
    logic        m_int, m_frz_hit, m_auto_end_of_service, m_init_busy;
    logic        s_int;
    logic        m_wr_base, m_wr_data, s_wr_base, s_wr_data;
    logic        m_rd_base, s_rd_base;
    logic        freeze, m_commit, s_commit, slv_match, m_release, s_release;
    cpai_ack_state_t state_ff, nxt_state;
    logic [2:0]  cas_bus_ff, nxt_cas_bus;
    logic        cas_valid_ff, nxt_cas_valid;
    logic        sel_ff, nxt_sel;
    logic [7:0]  vec_ff, nxt_vec;
    logic        vec_valid_ff, nxt_vec_valid;
    logic [7:0]  rdata_ff, nxt_rdata;
    logic        rvalid_ff, nxt_rvalid;
    logic        int_n_ff;

    // request pins cross into the system clock
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            irq_s1_ff <= 16'h0000;
            irq_s2_ff <= 16'h0000;
        end else begin
            irq_s1_ff <= I_IRQ;
            irq_s2_ff <= irq_s1_ff;
        end
    end

    // port decode
    always_comb begin
        m_wr_base = I_IO_WR && (I_IO_ADDR == MST_BASE_ADDR);
        m_wr_data = I_IO_WR && (I_IO_ADDR == MST_DATA_ADDR);
        s_wr_base = I_IO_WR && (I_IO_ADDR == SLV_BASE_ADDR);
        s_wr_data = I_IO_WR && (I_IO_ADDR == SLV_DATA_ADDR);
        m_rd_base = I_IO_RD && (I_IO_ADDR == MST_BASE_ADDR);
        s_rd_base = I_IO_RD && (I_IO_ADDR == SLV_BASE_ADDR);
    end

    // slave interrupt feeds the cascade input as a level
    always_comb begin
        m_req = irq_s2_ff[7:0];
        m_req[CASCADE_INPUT] = s_int;
        m_trig = I_TRIG_LEVEL[7:0];
        m_trig[CASCADE_INPUT] = 1'b1;
    end

    // acknowledge sequencer: one command gives two internal pulses
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:   if (I_INTERNAL_ACK_PULSE_CMD) nxt_state = ST_ACK1;
            ST_ACK1:   nxt_state = ST_TRAIL1;
            ST_TRAIL1: nxt_state = ST_ACK2;
            ST_ACK2:   nxt_state = ST_TRAIL2;
            ST_TRAIL2: nxt_state = ST_IDLE;
            default:   nxt_state = ST_IDLE;
        endcase
    end

    always_comb begin
        freeze    = (state_ff == ST_ACK1);
        m_commit  = freeze;
        slv_match = cas_valid_ff && (cas_bus_ff == s_cascade[2:0]);
        s_commit  = (state_ff == ST_ACK2) && slv_match;
        m_release = (state_ff == ST_TRAIL2);
        s_release = m_release && sel_ff;
    end

    always_comb begin
        nxt_cas_bus   = cas_bus_ff;
        nxt_cas_valid = cas_valid_ff;
        nxt_sel       = sel_ff;
        nxt_vec       = vec_ff;
        nxt_vec_valid = 1'b0;
        if (state_ff == ST_TRAIL1) begin
            nxt_cas_bus   = m_frz_lvl;
            nxt_cas_valid = m_frz_hit && m_cascade[m_frz_lvl];
        end
        if (state_ff == ST_ACK2) begin
            nxt_sel       = slv_match;
            nxt_vec       = slv_match ? s_vector : m_vector;
            nxt_vec_valid = 1'b1;
        end
        if (state_ff == ST_TRAIL2) nxt_cas_valid = 1'b0;
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            state_ff     <= ST_IDLE;
            cas_bus_ff   <= 3'h0;
            cas_valid_ff <= 1'b0;
            sel_ff       <= 1'b0;
            vec_ff       <= BYTE_ZERO;
            vec_valid_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            cas_bus_ff   <= nxt_cas_bus;
            cas_valid_ff <= nxt_cas_valid;
            sel_ff       <= nxt_sel;
            vec_ff       <= nxt_vec;
            vec_valid_ff <= nxt_vec_valid;
        end
    end

    // register reads; unmapped addresses give no valid
    always_comb begin
        nxt_rdata  = BYTE_ZERO;
        nxt_rvalid = 1'b0;
        if (I_IO_RD) begin
            nxt_rvalid = 1'b1;
            case (I_IO_ADDR)
                MST_BASE_ADDR: nxt_rdata = m_status;
                MST_DATA_ADDR: nxt_rdata = m_mask;
                SLV_BASE_ADDR: nxt_rdata = s_status;
                SLV_DATA_ADDR: nxt_rdata = s_mask;
                default:       nxt_rvalid = 1'b0;
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            rdata_ff  <= BYTE_ZERO;
            rvalid_ff <= 1'b0;
            int_n_ff  <= 1'b1;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            int_n_ff  <= ~m_int;
        end
    end

    cpai_core u_master (
        .i_clk        (I_CLK_SYS),
        .i_rst        (I_RST),
        .i_req        (m_req),
        .i_trig_level (m_trig),
        .i_wr_base    (m_wr_base),
        .i_wr_data    (m_wr_data),
        .i_wdata      (I_IO_WDATA),
        .i_rd_base    (m_rd_base),
        .i_freeze     (freeze),
        .i_commit     (m_commit),
        .i_release    (m_release),
        .o_int        (m_int),
        .o_vector     (m_vector),
        .o_status     (m_status),
        .o_mask       (m_mask),
        .o_cascade    (m_cascade),
        .o_irr        (m_irr),
        .o_isr        (m_isr),
        .o_frz_lvl    (m_frz_lvl),
        .o_frz_hit    (m_frz_hit),
        .o_auto_end_of_service       (m_auto_end_of_service),
        .o_init_busy  (m_init_busy)
    );

    cpai_core u_slave (
        .i_clk        (I_CLK_SYS),
        .i_rst        (I_RST),
        .i_req        (irq_s2_ff[15:8]),
        .i_trig_level (I_TRIG_LEVEL[15:8]),
        .i_wr_base    (s_wr_base),
        .i_wr_data    (s_wr_data),
        .i_wdata      (I_IO_WDATA),
        .i_rd_base    (s_rd_base),
        .i_freeze     (freeze),
        .i_commit     (s_commit),
        .i_release    (s_release),
        .o_int        (s_int),
        .o_vector     (s_vector),
        .o_status     (s_status),
        .o_mask       (s_mask),
        .o_cascade    (s_cascade),
        .o_irr        (),
        .o_isr        (),
        .o_frz_lvl    (),
        .o_frz_hit    (),
        .o_auto_end_of_service       (),
        .o_init_busy  ()
    );

    assign O_IO_RDATA     = rdata_ff;
    assign O_IO_RVALID    = rvalid_ff;
    assign O_CPU_INT_N    = int_n_ff;
    assign O_VECTOR       = vec_ff;
    assign O_VECTOR_VALID = vec_valid_ff;
    assign O_ACK_BUSY     = (state_ff != ST_IDLE);

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);

    // master input watched by the edge-latch check
    localparam int EDGE_PROBE = 3;

    chk_edge_sets_latch: assert property (
        (irq_s2_ff[EDGE_PROBE] && !$past(irq_s2_ff[EDGE_PROBE]) && !I_TRIG_LEVEL[EDGE_PROBE]
         && !I_IO_WR && !I_IO_RD && state_ff == ST_IDLE) |=> m_irr[EDGE_PROBE])
        else $error("rising request did not set request latch");

    chk_mask_blocks_int: assert property (
        !O_CPU_INT_N |-> $past(|(m_irr & ~m_mask)))
        else $error("interrupt raised with no unmasked request");

    chk_int_output_low: assert property (
        m_int |=> !O_CPU_INT_N)
        else $error("interrupt output not driven low");

    chk_ack_sets_service: assert property (
        (state_ff == ST_ACK1 && m_int) |=> (m_frz_hit && m_isr[m_frz_lvl]))
        else $error("first pulse did not set in-service bit");

    chk_two_pulse_seq: assert property (
        (state_ff == ST_IDLE && I_INTERNAL_ACK_PULSE_CMD) |=> state_ff == ST_ACK1 ##1 state_ff == ST_TRAIL1
        ##1 state_ff == ST_ACK2 ##1 state_ff == ST_TRAIL2 ##1 state_ff == ST_IDLE)
        else $error("acknowledge pulse sequence broken");

    chk_cascade_code: assert property (
        (state_ff == ST_TRAIL1 && m_frz_hit && m_frz_lvl == SLAVE_ID_CODE
         && m_cascade[CASCADE_INPUT]) |=> (cas_valid_ff && cas_bus_ff == SLAVE_ID_CODE))
        else $error("slave code not broadcast");

    chk_master_vector: assert property (
        (state_ff == ST_ACK2 && !slv_match) |=>
        (O_VECTOR_VALID && O_VECTOR == {$past(m_vector[7:3]), $past(m_frz_lvl)}))
        else $error("master vector wrong");

    chk_short_req_vec7: assert property (
        (state_ff == ST_ACK1 && !m_int) |=> ##2 (O_VECTOR_VALID && O_VECTOR[2:0] == LOWEST_LEVEL))
        else $error("default level 7 vector not returned");

    chk_auto_end_clear: assert property (
        (m_release && m_auto_end_of_service && m_frz_hit) |=> !m_isr[$past(m_frz_lvl)])
        else $error("automatic end of service did not clear");

    chk_init_clears_mask: assert property (
        (m_wr_base && I_IO_WDATA[INIT_BIT]) |=> (m_mask == BYTE_ZERO && m_init_busy && m_irr == BYTE_ZERO))
        else $error("init did not clear mask and start sequence");

    chk_slave_vector: assert property (
        (state_ff == ST_ACK2 && slv_match) |=> (O_VECTOR == $past(s_vector) && sel_ff))
        else $error("slave vector not selected on match");

    chk_mask_write: assert property (
        (m_wr_data && !m_init_busy) |=> m_mask == $past(I_IO_WDATA))
        else $error("mask write not applied");

    chk_ns_eos_clears: assert property (
        (m_wr_base && I_IO_WDATA[7:5] == CMD_NS_EOS && !I_IO_WDATA[INIT_BIT]
         && !I_IO_WDATA[OP_WORD_READ_POLL_SEL_BIT] && m_isr != BYTE_ZERO && m_mask == BYTE_ZERO
         && state_ff == ST_IDLE) |=> $countones(m_isr) == $countones($past(m_isr)) - 1)
        else $error("end of service did not clear one bit");
endmodule

// *** cpai_host_model.sv ***
// cpai_host_model: processor side that issues acknowledge commands.
// assumes the bench calls ack; signals move 1 ns after a rising edge.
`timescale 1ns/100ps
module cpai_host_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_vec,
    input  wire logic       i_vvalid,
    output logic            o_internal_ack_pulse_cmd
);
    initial o_internal_ack_pulse_cmd = 1'b0;
    // one-cycle command, then bounded wait for the vector mark
    task automatic ack(output logic [7:0] vec, output logic ok);
        @(posedge i_clk) #1 o_internal_ack_pulse_cmd = 1'b1;
        @(posedge i_clk) #1 o_internal_ack_pulse_cmd = 1'b0;
        for (int n = 0; n < 8 && i_vvalid !== 1'b1; n++) @(posedge i_clk) #1;
        ok = i_vvalid;
        vec = i_vec;
    endtask
endmodule

// *** testbench.sv ***
// testbench: drives the controller pair through port writes and acknowledges.
// assumes cpai_top and cpai_host_model; edge mode except input 1 in t_level.
`timescale 1ns/100ps
module testbench import cpai_pkg::*;;
    logic clk, rst, wr, rd, int_n, rvalid, vvalid, busy, ok, internal_ack_pulse;
    logic [15:0] irq, addr, trig;
    logic [7:0] wdata, rdata, vec, v;
    int n_errors = 0, total_checks = 0, cyc = 0;
    cpai_top cpai_top_inst (.I_CLK_SYS(clk), .I_RST(rst), .I_IRQ(irq),
        .I_TRIG_LEVEL(trig), .I_IO_ADDR(addr), .I_IO_WR(wr), .I_IO_RD(rd),
        .I_IO_WDATA(wdata), .I_INTERNAL_ACK_PULSE_CMD(internal_ack_pulse), .O_IO_RDATA(rdata),
        .O_IO_RVALID(rvalid), .O_CPU_INT_N(int_n), .O_VECTOR(vec),
        .O_VECTOR_VALID(vvalid), .O_ACK_BUSY(busy));
    cpai_host_model cpai_host_model_inst (.i_clk(clk), .i_vec(vec),
        .i_vvalid(vvalid), .o_internal_ack_pulse_cmd(internal_ack_pulse));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) #1 {wr, rd, addr, wdata} = {w, !w, a, d};
        @(posedge clk) #1 {wr, rd} = 2'b00;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        io(1'b0, a, 8'h00);
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, exp);
    endtask
    task automatic irq_on(input int b);
        @(posedge clk) #1 irq[b] = 1'b1;
        for (int n = 0; n < 10 && int_n !== 1'b0; n++) @(posedge clk) #1;
        chk({7'h00, int_n}, 8'h00);
    endtask
    task automatic t_init();
        io(1'b1, MST_BASE_ADDR, 8'h11);
        io(1'b1, MST_DATA_ADDR, 8'h08);
        io(1'b1, MST_DATA_ADDR, 8'h04);
        io(1'b1, MST_DATA_ADDR, 8'h01);
        io(1'b1, SLV_BASE_ADDR, 8'h11);
        io(1'b1, SLV_DATA_ADDR, 8'h70);
        io(1'b1, SLV_DATA_ADDR, 8'h02);
        io(1'b1, SLV_DATA_ADDR, 8'h01);
        rdchk(MST_DATA_ADDR, 8'h00);
        rdchk(SLV_DATA_ADDR, 8'h00);
    endtask
    task automatic t_master();
        irq_on(3);
        cpai_host_model_inst.ack(v, ok);
        chk({7'h00, ok}, 8'h01);
        chk({7'h00, busy}, 8'h01);
        chk(v, 8'h0B);
        io(1'b1, MST_BASE_ADDR, 8'h0B);
        rdchk(MST_BASE_ADDR, 8'h08);
        io(1'b1, MST_BASE_ADDR, 8'h20);
        rdchk(MST_BASE_ADDR, 8'h00);
        irq[3] = 1'b0;
    endtask
    task automatic t_slave();
        irq_on(13);
        cpai_host_model_inst.ack(v, ok);
        chk(v, 8'h75);
        rdchk(MST_BASE_ADDR, 8'h04);
        io(1'b1, SLV_BASE_ADDR, 8'h0B);
        rdchk(SLV_BASE_ADDR, 8'h20);
        io(1'b1, SLV_BASE_ADDR, 8'h20);
        io(1'b1, MST_BASE_ADDR, 8'h20);
        irq[13] = 1'b0;
    endtask
    task automatic t_mask();
        io(1'b1, MST_DATA_ADDR, 8'h08);
        irq[3] = 1'b1;
        repeat (8) @(posedge clk);
        #1 chk({7'h00, int_n}, 8'h01);
        io(1'b1, MST_BASE_ADDR, 8'h0A);
        rdchk(MST_BASE_ADDR, 8'h08);
        cpai_host_model_inst.ack(v, ok);
        chk(v, 8'h0F);
    endtask
    task automatic t_auto();
        io(1'b1, MST_BASE_ADDR, 8'h11);
        io(1'b1, MST_DATA_ADDR, 8'h08);
        io(1'b1, MST_DATA_ADDR, 8'h04);
        io(1'b1, MST_DATA_ADDR, 8'h03);
        rdchk(MST_BASE_ADDR, 8'h00);
        repeat (4) @(posedge clk);
        #1 chk({7'h00, int_n}, 8'h01);
        irq[3] = 1'b0;
        repeat (4) @(posedge clk);
        irq_on(3);
        cpai_host_model_inst.ack(v, ok);
        chk(v, 8'h0B);
        @(posedge clk) #1 chk({7'h00, busy}, 8'h00);
        io(1'b1, MST_BASE_ADDR, 8'h0B);
        rdchk(MST_BASE_ADDR, 8'h00);
        irq[3] = 1'b0;
    endtask
    task automatic t_level();
        trig[1] = 1'b1;
        irq_on(1);
        io(1'b1, MST_BASE_ADDR, 8'h0C);
        rdchk(MST_BASE_ADDR, 8'h81);
        io(1'b1, MST_BASE_ADDR, 8'h0B);
        rdchk(MST_BASE_ADDR, 8'h02);
        io(1'b1, MST_BASE_ADDR, 8'h61);
        rdchk(MST_BASE_ADDR, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, int_n}, 8'h00);
        irq[1] = 1'b0;
        trig[1] = 1'b0;
    endtask
    initial begin
        {rst, wr, rd, irq, addr, wdata} = {1'b1, 42'h0};
        trig = 16'h0000;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        t_init();
        t_master();
        t_slave();
        t_mask();
        t_auto();
        t_level();
        stop_test();
    end
endmodule
